//--- pkg/qrbt_pkg.sv
// Constants, register map and shared helpers of the quad registered bus transceiver.
// Assumes one core clock; the APB slave lives in the top module.
//
// Operation
// - Select low routes the first data word to the driver register input.
// - Select high routes the second data word to the driver register input.
// - Driver register loads only from the driver register clock input.
// - Driver register captures on the rising transition of that clock.
// - Drive enable high releases the bus; low drives it from the register.
// - Receiver output is the complement of the bus line it sees.
// - Drivers place the complement of the register bit on the bus.
// - Latch enable low makes the receiver latches transparent to the inverted bus.
// - Latch enable high holds the latches regardless of all other inputs.
// - Receiver output enable high floats the outputs; low shows latch contents.
// - Driver enabled: parity is odd parity of the selected input word.
// - Driver disabled, latches open: parity follows the received bus data.
// - Drive enable picks the parity mode: low generates, high checks.
// - Check mode parity comes from the latch outputs, stable while closed.
package qrbt_pkg;

    // ========================================================================
    // Widths
    localparam int QRBT_NBITS = 4;
    localparam int QRBT_AW    = 8;
    localparam int QRBT_DW    = 32;
    localparam int QRBT_CW    = 16;

    // ========================================================================
    // Register byte offsets
    localparam logic [7:0] QRBT_CTRL_OFS   = 8'h00;
    localparam logic [7:0] QRBT_WORDS_OFS  = 8'h04;
    localparam logic [7:0] QRBT_STATUS_OFS = 8'h08;
    localparam logic [7:0] QRBT_LOADS_OFS  = 8'h0c;
    localparam logic [7:0] QRBT_FLAGS_OFS  = 8'h10;

    // ========================================================================
    // Field positions
    localparam int QRBT_CTRL_SEL_BIT  = 0;
    localparam int QRBT_CTRL_BEN_BIT  = 1;
    localparam int QRBT_CTRL_RLEN_BIT = 2;
    localparam int QRBT_CTRL_OEN_BIT  = 3;
    localparam int QRBT_WORDS_A_LSB   = 0;
    localparam int QRBT_WORDS_B_LSB   = 4;
    localparam int QRBT_ST_DRV_LSB    = 0;
    localparam int QRBT_ST_LAT_LSB    = 4;
    localparam int QRBT_ST_BUS_LSB    = 8;
    localparam int QRBT_ST_PAR_BIT    = 12;
    localparam int QRBT_ST_MODE_BIT   = 13;
    localparam int QRBT_FL_EVEN_BIT   = 0;

    // ========================================================================
    // Reset values: bus released, latches closed, outputs floating
    localparam logic [3:0] QRBT_CTRL_RST  = 4'he;
    localparam logic [7:0] QRBT_WORDS_RST = 8'h00;

    // Odd parity bit: high when the word holds an even number of ones
    function automatic logic qrbt_odd_par(input logic [QRBT_NBITS-1:0] w);
        qrbt_odd_par = ~(^w);
    endfunction

endpackage

//--- logic/qrbt_drv_reg.sv
// Input multiplexer and four-bit driver register of the transceiver.
// Assumes the load strobe is a one-cycle pulse in the core clock domain.
`timescale 1ns/10ps
module qrbt_drv_reg
    import qrbt_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  select_i,
    input  wire logic [QRBT_NBITS-1:0] a_word_i,
    input  wire logic [QRBT_NBITS-1:0] b_word_i,
    input  wire logic                  load_i,
    output logic      [QRBT_NBITS-1:0] mux_o,
    output logic      [QRBT_NBITS-1:0] drv_q_o
);

    // ========================================================================
    // Word select ahead of the register
    always_comb begin
        mux_o = select_i ? b_word_i : a_word_i;
    end

    // ========================================================================
    // Driver register, deliberately without reset
    always_ff @(posedge core_clk_i) begin
        if (load_i) begin
            drv_q_o <= mux_o;
        end
    end

endmodule

//--- logic/qrbt_rcv_latch.sv
// Four receiver latches with inverting inputs.
// Assumes the bus levels are already synchronous to the core clock.
`timescale 1ns/10ps
module qrbt_rcv_latch
    import qrbt_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  latch_enable_n_i,
    input  wire logic [QRBT_NBITS-1:0] bus_n_i,
    output logic      [QRBT_NBITS-1:0] lat_q_o
);

    // ========================================================================
    // Open latch samples every cycle; a closed one keeps its word.
    // A true latch would be glitch prone here, so it follows one clock late.
    always_ff @(posedge core_clk_i) begin
        if (!latch_enable_n_i) begin
            lat_q_o <= ~bus_n_i;
        end
    end

endmodule

//--- logic/qrbt_top.sv
// Top of the quad registered bus transceiver with its APB register slave.
// Assumes all pins are synchronous to core_clk_i and that the system
// arbitrates the shared bus between transceivers.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
module qrbt_top
    import qrbt_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  resetn_i,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [QRBT_AW-1:0]    paddr,
    input  wire logic [QRBT_DW-1:0]    pwdata,
    output logic      [QRBT_DW-1:0]    prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Driver register clock pin
    input  wire logic                  driver_reg_clock_i,
    // Shared bus, active low lines
    input  wire logic [QRBT_NBITS-1:0] bus_n_i,
    output logic      [QRBT_NBITS-1:0] bus_n_o,
    output logic      [QRBT_NBITS-1:0] bus_n_oe_o,
    // Receiver outputs, three-state
    output logic      [QRBT_NBITS-1:0] rcv_o,
    output logic      [QRBT_NBITS-1:0] rcv_oe_o,
    // Odd parity output
    output logic                       parity_o
);

    // ========================================================================
    // Declarations
    logic                  select;
    logic                  bus_drive_enable_n;
    logic                  receive_latch_enable_n;
    logic                  rcv_output_enable_n;
    logic [QRBT_NBITS-1:0] a_word;
    logic [QRBT_NBITS-1:0] b_word;
    logic                  drv_clk_prev;
    logic                  drv_load;
    logic [QRBT_NBITS-1:0] mux_word;
    logic [QRBT_NBITS-1:0] drv_q;
    logic [QRBT_NBITS-1:0] lat_q;
    logic                  gen_parity;
    logic                  chk_parity;
    logic [QRBT_CW-1:0]    load_count;
    logic                  even_seen;
    logic                  even_event;
    logic                  setup_phase;
    logic                  access_phase;
    logic                  wr_access;
    logic                  addr_ok;
    logic [QRBT_DW-1:0]    next_rdata;
    logic                  fl_clear;

    // ========================================================================
    // APB phase decode
    // Setup is the first cycle of a transfer; access completes at once.
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign wr_access    = access_phase & pwrite;

    // Zero wait states: every access finishes in its first access cycle
    assign pready = 1'b1;

    // Address decode for the error flag; the read mux decodes paddr in its own case
    function automatic logic addr_mapped(input logic [QRBT_AW-1:0] a);
        addr_mapped = (a == QRBT_CTRL_OFS)   ||
                      (a == QRBT_WORDS_OFS)  ||
                      (a == QRBT_STATUS_OFS) ||
                      (a == QRBT_LOADS_OFS)  ||
                      (a == QRBT_FLAGS_OFS);
    endfunction

    assign addr_ok = addr_mapped(paddr);

    // ========================================================================
    // Control register: mode pins of the transceiver under software control
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            select                 <= QRBT_CTRL_RST[QRBT_CTRL_SEL_BIT];
            bus_drive_enable_n     <= QRBT_CTRL_RST[QRBT_CTRL_BEN_BIT];
            receive_latch_enable_n <= QRBT_CTRL_RST[QRBT_CTRL_RLEN_BIT];
            rcv_output_enable_n    <= QRBT_CTRL_RST[QRBT_CTRL_OEN_BIT];
        end else if (wr_access && paddr == QRBT_CTRL_OFS) begin
            select                 <= pwdata[QRBT_CTRL_SEL_BIT];
            bus_drive_enable_n     <= pwdata[QRBT_CTRL_BEN_BIT];
            receive_latch_enable_n <= pwdata[QRBT_CTRL_RLEN_BIT];
            rcv_output_enable_n    <= pwdata[QRBT_CTRL_OEN_BIT];
        end
    end

    // ========================================================================
    // Input words presented to the multiplexer
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            a_word <= QRBT_WORDS_RST[QRBT_WORDS_A_LSB +: QRBT_NBITS];
            b_word <= QRBT_WORDS_RST[QRBT_WORDS_B_LSB +: QRBT_NBITS];
        end else if (wr_access && paddr == QRBT_WORDS_OFS) begin
            a_word <= pwdata[QRBT_WORDS_A_LSB +: QRBT_NBITS];
            b_word <= pwdata[QRBT_WORDS_B_LSB +: QRBT_NBITS];
        end
    end

    // ========================================================================
    // Driver register clock edge detect
    // Held high in reset so a pin already high at release is no edge.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            drv_clk_prev <= 1'b1;
        end else begin
            drv_clk_prev <= driver_reg_clock_i;
        end
    end

    // Only the rising transition of the pin loads the register
    assign drv_load = driver_reg_clock_i & ~drv_clk_prev;

    // ========================================================================
    // Multiplexer and driver register
    qrbt_drv_reg u_drv_reg (
        .core_clk_i (core_clk_i),
        .select_i   (select),
        .a_word_i   (a_word),
        .b_word_i   (b_word),
        .load_i     (drv_load),
        .mux_o      (mux_word),
        .drv_q_o    (drv_q)
    );

    // ========================================================================
    // Bus drivers: inverted register bits, released when disabled.
    // Contention with other transceivers is not detected here; the
    // system must keep at most one of them enabled.
    assign bus_n_o    = ~drv_q;
    assign bus_n_oe_o = {QRBT_NBITS{~bus_drive_enable_n}};

    // ========================================================================
    // Receiver latches fed from the bus pins as seen at the device
    qrbt_rcv_latch u_rcv_latch (
        .core_clk_i       (core_clk_i),
        .latch_enable_n_i (receive_latch_enable_n),
        .bus_n_i          (bus_n_i),
        .lat_q_o          (lat_q)
    );

    // ========================================================================
    // Receiver outputs: latch contents, floated by the output enable
    assign rcv_o    = lat_q;
    assign rcv_oe_o = {QRBT_NBITS{~rcv_output_enable_n}};

    // ========================================================================
    // Parity generator and checker
    // Generate looks at the word ahead of the register, so it leads the
    // bus by one driver clock; check looks at the latches, not the bus.
    assign gen_parity = qrbt_odd_par(mux_word);
    assign chk_parity = qrbt_odd_par(lat_q);
    assign parity_o   = bus_drive_enable_n ? chk_parity
                                           : gen_parity;

    // ========================================================================
    // Load counter: driver register captures since reset, wraps around
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            load_count <= '0;
        end else if (drv_load) begin
            load_count <= load_count + 16'h0001;
        end
    end

    // ========================================================================
    // Sticky flag: check mode saw received data with odd bit count,
    // meaning the parity output went low. Write one to clear; an event in
    // the clearing cycle keeps the flag set.
    assign even_event = bus_drive_enable_n & ~chk_parity;
    assign fl_clear   = wr_access & (paddr == QRBT_FLAGS_OFS)
                        & pwdata[QRBT_FL_EVEN_BIT];

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            even_seen <= 1'b0;
        end else if (even_event) begin
            even_seen <= 1'b1;
        end else if (fl_clear) begin
            even_seen <= 1'b0;
        end
    end

    // ========================================================================
    // Read data assembly, taken from the setup cycle
    always_comb begin
        next_rdata = '0;
        case (paddr)
            QRBT_CTRL_OFS: begin
                next_rdata[QRBT_CTRL_SEL_BIT]  = select;
                next_rdata[QRBT_CTRL_BEN_BIT]  = bus_drive_enable_n;
                next_rdata[QRBT_CTRL_RLEN_BIT] = receive_latch_enable_n;
                next_rdata[QRBT_CTRL_OEN_BIT]  = rcv_output_enable_n;
            end
            QRBT_WORDS_OFS: begin
                next_rdata[QRBT_WORDS_A_LSB +: QRBT_NBITS] = a_word;
                next_rdata[QRBT_WORDS_B_LSB +: QRBT_NBITS] = b_word;
            end
            QRBT_STATUS_OFS: begin
                next_rdata[QRBT_ST_DRV_LSB +: QRBT_NBITS] = drv_q;
                next_rdata[QRBT_ST_LAT_LSB +: QRBT_NBITS] = lat_q;
                next_rdata[QRBT_ST_BUS_LSB +: QRBT_NBITS] = bus_n_i;
                next_rdata[QRBT_ST_PAR_BIT]               = parity_o;
                next_rdata[QRBT_ST_MODE_BIT]              = bus_drive_enable_n;
            end
            QRBT_LOADS_OFS: begin
                next_rdata[QRBT_CW-1:0] = load_count;
            end
            QRBT_FLAGS_OFS: begin
                next_rdata[QRBT_FL_EVEN_BIT] = even_seen;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // ========================================================================
    // Read data and error registered in setup, stable through access.
    // Status is thus a snapshot one cycle old at the completing edge.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata <= '0;
        end else if (setup_phase) begin
            prdata <= pwrite ? '0 : next_rdata;
        end
    end

    // Unmapped or misaligned addresses answer with an error
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= ~addr_ok;
        end
    end

endmodule

//--- dv/qrbt_sva.sv
// Port-level checker of the transceiver top.
// Assumes a bind to qrbt_top; one clock, active-low async reset.
`timescale 1ns/10ps
module qrbt_sva
    import qrbt_pkg::*;
(
    input wire logic                  core_clk_i,
    input wire logic                  resetn_i,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [QRBT_AW-1:0]    paddr,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  driver_reg_clock_i,
    input wire logic [QRBT_NBITS-1:0] bus_n_i,
    input wire logic [QRBT_NBITS-1:0] bus_n_o,
    input wire logic [QRBT_NBITS-1:0] bus_n_oe_o,
    input wire logic [QRBT_NBITS-1:0] rcv_o,
    input wire logic [QRBT_NBITS-1:0] rcv_oe_o,
    input wire logic                  parity_o
);
    // ========================================================================
    // Helpers
    logic pin_q;
    logic loaded;
    wire  rise = driver_reg_clock_i && !pin_q;
    wire  wr   = psel && penable && pwrite;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // History starts high, so a pin already high at release is no edge
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_q  <= 1'b1;
            loaded <= 1'b0;
        end else begin
            pin_q  <= driver_reg_clock_i;
            loaded <= loaded | rise;
        end
    end
    // ========================================================================
    // Properties
    property p_drv_hold;
        loaded && !rise |=> bus_n_o == $past(bus_n_o);
    endproperty
    a_drv_hold: assert property (p_drv_hold) else $error("bus moved without pin edge");
    property p_gen;
        rise && !wr && bus_n_oe_o == 4'hf |=> parity_o == ~^(~bus_n_o);
    endproperty
    a_gen: assert property (p_gen) else $error("loaded word and parity differ");
    property p_oe;
        $changed(bus_n_oe_o) |-> $past(wr) && $past(paddr) == QRBT_CTRL_OFS;
    endproperty
    a_oe: assert property (p_oe) else $error("bus enable moved without write");
    property p_roe;
        $changed(rcv_oe_o) |-> $past(wr) && $past(paddr) == QRBT_CTRL_OFS;
    endproperty
    a_roe: assert property (p_roe) else $error("output enable moved without write");
    property p_rcv;
        $changed(rcv_o) |-> rcv_o == ~$past(bus_n_i);
    endproperty
    a_rcv: assert property (p_rcv) else $error("receiver not inverted bus");
    property p_chk;
        bus_n_oe_o == 4'h0 && rcv_oe_o == 4'hf |-> parity_o == ~^rcv_o;
    endproperty
    a_chk: assert property (p_chk) else $error("check parity not from latches");
    property p_rdy;
        psel && !penable |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready in access");
    property p_err;
        psel && !penable && paddr[1:0] != 2'b00 |=> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("misaligned access not refused");
endmodule

//--- dv/qrbt_bus_peer.sv
// Far side: a second transceiver on the four shared bus lines.
// Assumes the bench merges its lines with the device's by the enables.
`timescale 1ns/10ps
module qrbt_bus_peer
    import qrbt_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  drive_req_i,
    input  wire logic                  dut_drives_i,
    input  wire logic [QRBT_NBITS-1:0] word_i,
    output logic      [QRBT_NBITS-1:0] bus_n_o
);
    // ========================================================================
    // Line drive
    // Yields while the device drives; idle lines rest at the pull-up level
    always_ff @(posedge core_clk_i) begin
        if (drive_req_i && !dut_drives_i) begin
            bus_n_o <= ~word_i;
        end else begin
            bus_n_o <= 4'hf;
        end
    end
endmodule

//--- dv/qrbt_top_tb.sv
// Self-checking bench of the transceiver top with a bus peer.
// Assumes package, design, checker and peer are compiled first.
`timescale 1ns/10ps
module qrbt_top_tb
    import qrbt_pkg::*;
;
    // ========================================================================
    // Signals
    logic                  core_clk_i = 1'b0;
    logic                  resetn_i   = 1'b0;
    logic                  psel       = 1'b0;
    logic                  penable    = 1'b0;
    logic                  pwrite     = 1'b0;
    logic [QRBT_AW-1:0]    paddr      = 8'h00;
    logic [QRBT_DW-1:0]    pwdata     = 32'h0;
    logic                  driver_reg_clock_i = 1'b0;
    logic                  peer_req   = 1'b0;
    logic [QRBT_NBITS-1:0] peer_word  = 4'h0;
    logic [QRBT_DW-1:0]    prdata, rd;
    logic                  pready, pslverr, err, parity_o;
    logic [QRBT_NBITS-1:0] bus_n_i, bus_n_o, bus_n_oe_o, rcv_o, rcv_oe_o, peer_n;
    int                    miscompares = 0;
    int                    tests_run   = 0;
    // 25 MHz core clock
    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end
    // Wire level: own drive wins, else peer or pull-up
    assign bus_n_i = (|bus_n_oe_o) ? bus_n_o : peer_n;
    qrbt_top i_dut (.core_clk_i, .resetn_i, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .driver_reg_clock_i, .bus_n_i, .bus_n_o,
        .bus_n_oe_o, .rcv_o, .rcv_oe_o, .parity_o);
    qrbt_bus_peer i_peer (.core_clk_i, .drive_req_i(peer_req), .dut_drives_i(|bus_n_oe_o),
        .word_i(peer_word), .bus_n_o(peer_n));
    // ========================================================================
    // Shared tasks
    function automatic logic [31:0] z(input logic [3:0] v);
        return {28'h0, v};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // Request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        @(posedge core_clk_i);
        while (pready !== 1'b1) @(posedge core_clk_i);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // One pin edge, then time for bus and latch to settle
    task automatic pulse;
        @(posedge core_clk_i);
        driver_reg_clock_i <= 1'b1;
        @(posedge core_clk_i);
        driver_reg_clock_i <= 1'b0;
        tick(2);
    endtask
    // ========================================================================
    // Scenarios
    task automatic t_reset;
        apb(1'b0, QRBT_CTRL_OFS, 32'h0);
        chk(rd, z(QRBT_CTRL_RST));
        chk(z(bus_n_oe_o), 32'h0);
        chk(z(rcv_oe_o), 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk(z(err), 32'h1);
        apb(1'b1, 8'h06, 32'h1);
        chk(z(err), 32'h1);
        $display("test reset done");
    endtask
    task automatic t_drive;
        logic [3:0] w;
        apb(1'b1, QRBT_WORDS_OFS, 32'ha5);
        for (int s = 0; s < 2; s++) begin
            w = (s == 0) ? 4'h5 : 4'ha;
            // Select s, bus driven, latch open, outputs on
            apb(1'b1, QRBT_CTRL_OFS, 32'(s));
            pulse();
            chk(z(bus_n_o), z(~w));
            chk(z(bus_n_oe_o), 32'hf);
            chk(z(rcv_o), z(w));
            chk(z(parity_o), z(~^w));
        end
        // Snapshot: drv a, latch a, bus 5, parity 1, generate mode
        apb(1'b0, QRBT_STATUS_OFS, 32'h0);
        chk(rd, 32'h15aa);
        // New words but no pin edge: register keeps b
        apb(1'b1, QRBT_WORDS_OFS, 32'h3c);
        tick(3);
        chk(z(bus_n_o), 32'h5);
        chk(z(parity_o), 32'h1);
        // Two pin edges so far, one load each
        apb(1'b0, QRBT_LOADS_OFS, 32'h0);
        chk(rd, 32'h2);
        $display("test drive done");
    endtask
    task automatic t_receive;
        apb(1'b1, QRBT_CTRL_OFS, 32'h2);
        peer_word <= 4'h7;
        peer_req  <= 1'b1;
        tick(3);
        chk(z(rcv_o), 32'h7);
        chk(z(parity_o), 32'h0);
        chk(z(rcv_oe_o), 32'hf);
        // Odd bit count seen in check mode; clear loses to a live event
        apb(1'b1, QRBT_FLAGS_OFS, 32'h1);
        apb(1'b0, QRBT_FLAGS_OFS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, QRBT_CTRL_OFS, 32'h6);
        peer_word <= 4'h8;
        tick(3);
        chk(z(rcv_o), 32'h7);
        chk(z(parity_o), 32'h0);
        apb(1'b1, QRBT_CTRL_OFS, 32'he);
        peer_req <= 1'b0;
        tick(1);
        chk(z(rcv_oe_o), 32'h0);
        $display("test receive done");
    endtask
    // Mid-run reset must leave the driver register alone
    task automatic t_rereset;
        // Drive mode removes the flag source, so a write of one clears it
        apb(1'b1, QRBT_CTRL_OFS, 32'h0);
        apb(1'b1, QRBT_FLAGS_OFS, 32'h1);
        apb(1'b0, QRBT_FLAGS_OFS, 32'h0);
        chk(rd, 32'h0);
        chk(z(bus_n_oe_o), 32'hf);
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        tick(2);
        chk(z(bus_n_oe_o), 32'h0);
        chk(z(bus_n_o), 32'h5);
        @(posedge core_clk_i);
        resetn_i <= 1'b1;
        apb(1'b0, QRBT_CTRL_OFS, 32'h0);
        chk(rd, z(QRBT_CTRL_RST));
        // Load counter restarts, driver register does not
        apb(1'b0, QRBT_LOADS_OFS, 32'h0);
        chk(rd, 32'h0);
        chk(z(bus_n_o), 32'h5);
        $display("test rereset done");
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ========================================================================
    // Main sequence and watchdog
    initial begin
        repeat (8) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_drive();
        t_receive();
        t_rereset();
        test_done();
    end
    initial begin
        #20000;
        miscompares++;
        test_done();
    end
endmodule
bind qrbt_top qrbt_sva i_sva (.core_clk_i, .resetn_i, .psel, .penable, .pwrite, .paddr,
    .pready, .pslverr, .driver_reg_clock_i, .bus_n_i, .bus_n_o, .bus_n_oe_o, .rcv_o,
    .rcv_oe_o, .parity_o);
